// ### ifat_params.svh
// constants of the instruction fetch address trap block
// assumes inclusion by bare name from every design file that needs it
`ifndef IFAT_PARAMS_SVH
`define IFAT_PARAMS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define IFAT_ADDR_W 8
`define IFAT_OFS_CTRL1 8'h00
`define IFAT_OFS_CODE 8'h04
`define IFAT_OFS_STAT 8'h08
`define IFAT_OFS_MASK 8'h0c
`define IFAT_OFS_CFG 8'h10

// ----------------------------------------
// fields and values
// ----------------------------------------
`define IFAT_BIT_RAM_SEL 5
`define IFAT_BIT_ACTION 4
`define IFAT_WD_LSB 0
`define IFAT_WD_MSB 3
`define IFAT_CTRL1_RESET 8'h39
`define IFAT_CODE_AREA 8'hd2
`define IFAT_ST_NMI 0
`define IFAT_ST_RST 1
`define IFAT_ST_W 2
`define IFAT_RESP_OKAY 2'h0
`define IFAT_RESP_SLVERR 2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define IFAT_CLK_PERIOD_NS 20
`define IFAT_TRAP_FC_PERIODS 24
`define IFAT_FC_KHZ 16000

// ----------------------------------------
// address areas
// ----------------------------------------
`define IFAT_SFR_BASE 16'h0000
`define IFAT_SFR_LAST 16'h003f
`define IFAT_RAM_BASE 16'h0040
`define IFAT_RAM_LAST 16'h023f

`endif

// ### ifat_pkg.sv
// types shared by the address trap modules
// assumes nothing of its surroundings
package ifat_pkg;
  typedef enum logic {IFAT_RP_IDLE, IFAT_RP_HOLD} ifat_rp_state_type;
  typedef logic [1:0] ifat_resp_type;
endpackage

// ### ifat_range_check.sv
// classifies a fetch address into the register area and the internal ram
// assumes a 16-bit code address from the fetch stage on the same clock
`timescale 1ns/10ps
`include "ifat_params.svh"

module ifat_range_check #(
  parameter logic [15:0] SFR_BASE = `IFAT_SFR_BASE,
  parameter logic [15:0] SFR_LAST = `IFAT_SFR_LAST,
  parameter logic [15:0] RAM_BASE = `IFAT_RAM_BASE,
  parameter logic [15:0] RAM_LAST = `IFAT_RAM_LAST
)(
  input wire logic [15:0] addr,
  output logic sfr_hit,
  output logic ram_hit
);

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  if (SFR_LAST < SFR_BASE || RAM_LAST < RAM_BASE)
  begin : g_chk
    $error("ifat_range_check: area ends before it begins");
  end

  assign sfr_hit = in_range(addr, SFR_BASE, SFR_LAST);
  assign ram_hit = in_range(addr, RAM_BASE, RAM_LAST);

endmodule

// ### ifat_reset_pulse.sv
// stretches a trap into an internal hardware reset of a fixed length
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/10ps
`include "ifat_params.svh"

module ifat_reset_pulse #(
  parameter int CYCLES = 75
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  output logic rst_n_o,
  output logic busy
);

  ifat_pkg::ifat_rp_state_type state_ff;
  logic [12:0] cnt_ff;
  logic [12:0] low_cnt_ff;

  if (CYCLES < 1 || CYCLES > 4096)
  begin : g_chk
    $error("ifat_reset_pulse: CYCLES out of range");
  end

  assign busy = (state_ff == ifat_pkg::IFAT_RP_HOLD);

  // ----------------------------------------
  // hold counter
  // ----------------------------------------
  // [R9] bounded reset length
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= ifat_pkg::IFAT_RP_IDLE;
      cnt_ff <= 13'h0000;
      rst_n_o <= 1'b1;
    end
    else
    begin
      unique case (state_ff)
        ifat_pkg::IFAT_RP_IDLE:
        begin
          if (start)
          begin
            state_ff <= ifat_pkg::IFAT_RP_HOLD;
            cnt_ff <= 13'(CYCLES - 1);
            rst_n_o <= 1'b0;
          end
        end
        ifat_pkg::IFAT_RP_HOLD:
        begin
          if (cnt_ff == 13'h0000)
          begin
            state_ff <= ifat_pkg::IFAT_RP_IDLE;
            rst_n_o <= 1'b1;
          end
          else
            cnt_ff <= cnt_ff - 13'h0001;
        end
      endcase
    end
  end

  // helper: length of the current low phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      low_cnt_ff <= 13'h0000;
    else
      low_cnt_ff <= rst_n_o ? 13'h0000 : low_cnt_ff + 13'h0001;
  end

  reset_len_a: assert property (@(posedge clk) disable iff (!nrst) // [R9]
    !rst_n_o |-> low_cnt_ff < 13'(CYCLES))
    else $error("trap reset held longer than allowed");

  reset_full_a: assert property (@(posedge clk) disable iff (!nrst) // [R9]
    $rose(rst_n_o) |-> $past(low_cnt_ff) == 13'(CYCLES - 1))
    else $error("trap reset released early");

endmodule

// ### ifat_top.sv
// instruction fetch address trap with its axi4-lite register slave
// assumes fetch signals and nmi ack come from the cpu on CLK_SYS
`timescale 1ns/10ps
`include "ifat_params.svh"

// How it works
// [R1] ram select bit low lets code run from internal ram untrapped.
// [R2] new ram select value takes effect only after code d2h is written.
// [R3] any opcode fetch from the register area traps, always. The code ignores fetches while the trap reset is held.
// [R4] action bit picks response: 0 interrupt, 1 internal reset.
// [R5] action 0: register area or selected ram fetch raises the trap interrupt.
// [R6] trap interrupt is non-maskable, independent of the global enable flag.
// [R7] trap request is raised at once even while another interrupt is serviced.
// [R8] software sets the stack pointer first and avoids deep trap nesting.
// [R9] action 1: trapped fetch resets internal hardware for at most 24/fc.
// [R10] trap reset in low speed mode one restarts the high-speed oscillator.
// [R11] trap bits share the two watchdog control register addresses.
// [R12] code d2h arms the trap area; unknown codes do nothing.
// [R13] first control register is write-only; reads return don't-care (zero).
// [R14] only opcode fetches are checked; data accesses never trap.
module ifat_top #(
  parameter int FC_KHZ = `IFAT_FC_KHZ,
  parameter logic [15:0] SFR_BASE = `IFAT_SFR_BASE,
  parameter logic [15:0] SFR_LAST = `IFAT_SFR_LAST,
  parameter logic [15:0] RAM_BASE = `IFAT_RAM_BASE,
  parameter logic [15:0] RAM_LAST = `IFAT_RAM_LAST
)(
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [`IFAT_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [`IFAT_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic FETCH_VALID,
  input wire logic FETCH_OPCODE,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic NMI_ACK,
  input wire logic LOW_SPEED_MODE_ONE,
  output logic FETCH_TRAP_INTERRUPT,
  output logic TRAP_RESET_N,
  output logic HF_OSC_RESTART,
  output logic [3:0] GUARD_WD_FIELDS,
  output logic IRQ
);

  localparam int TRAP_RST_NS = (`IFAT_TRAP_FC_PERIODS * 1_000_000) / FC_KHZ;
  localparam int TRAP_RST_CYC_RAW = TRAP_RST_NS / `IFAT_CLK_PERIOD_NS;
  localparam int TRAP_RST_CYC = (TRAP_RST_CYC_RAW < 1) ? 1 : TRAP_RST_CYC_RAW;
  // a literal cannot be bit-selected, so the reset image is held as a constant
  localparam logic [7:0] CTRL1_RST = `IFAT_CTRL1_RESET;

  if (FC_KHZ < 1)
  begin : g_chk
    $error("ifat_top: FC_KHZ must be positive");
  end

  function automatic logic is_mapped(input logic [`IFAT_ADDR_W-1:0] a);
    is_mapped = (a == `IFAT_OFS_CTRL1) || (a == `IFAT_OFS_CODE) ||
                (a == `IFAT_OFS_STAT) || (a == `IFAT_OFS_MASK) ||
                (a == `IFAT_OFS_CFG);
  endfunction

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  logic aw_got_ff, w_got_ff, bvalid_ff, awready_ff, wready_ff;
  logic [`IFAT_ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff;
  wire aw_hs = S_AXI_AWVALID & awready_ff;
  wire w_hs = S_AXI_WVALID & wready_ff;
  wire wr_fire = aw_got_ff & w_got_ff & !bvalid_ff;
  wire nxt_bvalid = wr_fire | (bvalid_ff & !S_AXI_BREADY);
  wire nxt_aw_got = (aw_got_ff | aw_hs) & !wr_fire;
  wire nxt_w_got = (w_got_ff | w_hs) & !wr_fire;
  wire [`IFAT_ADDR_W-1:0] wa = {awaddr_ff[`IFAT_ADDR_W-1:2], 2'h0};
  wire wr_lane = wr_fire & wstrb_ff[0];
  wire wr_ctrl1 = wr_lane & (wa == `IFAT_OFS_CTRL1);
  wire wr_code = wr_lane & (wa == `IFAT_OFS_CODE);
  wire wr_mask = wr_lane & (wa == `IFAT_OFS_MASK);
  wire [7:0] wbyte = wdata_ff[7:0];

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bresp_ff <= `IFAT_RESP_OKAY;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= !nxt_aw_got & !nxt_bvalid;
      wready_ff <= !nxt_w_got & !nxt_bvalid;
      if (wr_fire)
        bresp_ff <= is_mapped(wa) ? `IFAT_RESP_OKAY : `IFAT_RESP_SLVERR;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      if (aw_hs)
        awaddr_ff <= S_AXI_AWADDR;
      if (w_hs)
      begin
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
      end
    end
  end

  assign S_AXI_AWREADY = awready_ff;
  assign S_AXI_WREADY = wready_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;

  // ----------------------------------------
  // shared control registers
  // ----------------------------------------
  logic pend_ram_sel_ff, act_ram_sel_ff, action_ff;
  logic [3:0] wd_fields_ff;
  // [R2] commit of the pending ram select
  wire code_commit = wr_code & (wbyte == `IFAT_CODE_AREA);

  // [R11] trap bits and watchdog fields share one write
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      pend_ram_sel_ff <= CTRL1_RST[`IFAT_BIT_RAM_SEL];
      act_ram_sel_ff <= CTRL1_RST[`IFAT_BIT_RAM_SEL];
      action_ff <= CTRL1_RST[`IFAT_BIT_ACTION];
      wd_fields_ff <= CTRL1_RST[`IFAT_WD_MSB:`IFAT_WD_LSB];
    end
    else
    begin
      if (wr_ctrl1)
      begin
        pend_ram_sel_ff <= wbyte[`IFAT_BIT_RAM_SEL];
        action_ff <= wbyte[`IFAT_BIT_ACTION];
        wd_fields_ff <= wbyte[`IFAT_WD_MSB:`IFAT_WD_LSB];
      end
      // [R12] only the area code acts here
      if (code_commit)
        act_ram_sel_ff <= pend_ram_sel_ff;
    end
  end

  assign GUARD_WD_FIELDS = wd_fields_ff;

  // ----------------------------------------
  // fetch check
  // ----------------------------------------
  logic sfr_hit, ram_hit, rst_busy;
  ifat_range_check #(
    .SFR_BASE(SFR_BASE),
    .SFR_LAST(SFR_LAST),
    .RAM_BASE(RAM_BASE),
    .RAM_LAST(RAM_LAST)
  ) u_range (
    .addr(FETCH_ADDR),
    .sfr_hit(sfr_hit),
    .ram_hit(ram_hit)
  );

  // [R14] opcode fetches only; fetches during the trap reset are void
  wire op_fetch = FETCH_VALID & FETCH_OPCODE & !rst_busy;
  // [R3] register area traps whatever the ram select, [R1] ram only when selected
  wire trap_now = op_fetch & (sfr_hit | (ram_hit & act_ram_sel_ff));
  // [R4] action bit steers the response
  wire trap_irq = trap_now & !action_ff;
  wire trap_rst = trap_now & action_ff;

  // ----------------------------------------
  // trap responses
  // ----------------------------------------
  logic nmi_ff, osc_ff;
  // [R5] [R6] [R7] raised at once, no enable or in-service gating
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      nmi_ff <= 1'b0;
    else
      nmi_ff <= trap_irq | (nmi_ff & !NMI_ACK);
  end

  // [R10] oscillator restart alongside a low speed trap reset
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      osc_ff <= 1'b0;
    else
      osc_ff <= trap_rst & LOW_SPEED_MODE_ONE;
  end

  // [R9] reset stretched to the fc-derived length
  ifat_reset_pulse #(
    .CYCLES(TRAP_RST_CYC)
  ) u_rst (
    .clk(CLK_SYS),
    .nrst(NRST),
    .start(trap_rst),
    .rst_n_o(TRAP_RESET_N),
    .busy(rst_busy)
  );

  assign FETCH_TRAP_INTERRUPT = nmi_ff;
  assign HF_OSC_RESTART = osc_ff;

  // ----------------------------------------
  // status, mask and interrupt line
  // ----------------------------------------
  logic [`IFAT_ST_W-1:0] status_ff, mask_ff;
  logic irq_ff;
  wire [`IFAT_ST_W-1:0] st_set = {trap_rst, trap_irq};
  wire ar_hs;
  wire [`IFAT_ADDR_W-1:0] ra = {S_AXI_ARADDR[`IFAT_ADDR_W-1:2], 2'h0};
  wire st_clr = ar_hs & (ra == `IFAT_OFS_STAT);
  // a set in the clearing cycle survives the read
  wire [`IFAT_ST_W-1:0] nxt_status = (status_ff & {`IFAT_ST_W{!st_clr}}) | st_set;

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      status_ff <= '0;
      mask_ff <= '0;
      irq_ff <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      if (wr_mask)
        mask_ff <= wbyte[`IFAT_ST_W-1:0];
      irq_ff <= |(nxt_status & (wr_mask ? wbyte[`IFAT_ST_W-1:0] : mask_ff));
    end
  end

  assign IRQ = irq_ff;

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  logic rvalid_ff, arready_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  assign ar_hs = S_AXI_ARVALID & arready_ff;
  wire nxt_rvalid = ar_hs | (rvalid_ff & !S_AXI_RREADY);
  wire [31:0] cfg_word = {29'h0000_0000, action_ff, pend_ram_sel_ff, act_ram_sel_ff};
  // [R13] write-only control and code registers read as zero
  wire [31:0] rd_mux =
    (ra == `IFAT_OFS_STAT) ? {{(32-`IFAT_ST_W){1'b0}}, status_ff} :
    (ra == `IFAT_OFS_MASK) ? {{(32-`IFAT_ST_W){1'b0}}, mask_ff} :
    (ra == `IFAT_OFS_CFG) ? cfg_word : 32'h0000_0000;

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `IFAT_RESP_OKAY;
    end
    else
    begin
      rvalid_ff <= nxt_rvalid;
      arready_ff <= !nxt_rvalid;
      if (ar_hs)
      begin
        rdata_ff <= rd_mux;
        rresp_ff <= is_mapped(ra) ? `IFAT_RESP_OKAY : `IFAT_RESP_SLVERR;
      end
    end
  end

  assign S_AXI_ARREADY = arready_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence code_write_s;
    wr_code && (wbyte == `IFAT_CODE_AREA);
  endsequence

  sequence sfr_fetch_s;
    FETCH_VALID && FETCH_OPCODE && sfr_hit && !rst_busy;
  endsequence

  code_commit_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // [R2]
    code_write_s |=> act_ram_sel_ff == $past(pend_ram_sel_ff))
    else $error("area code did not commit the ram select");

  code_other_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // [R12]
    !code_commit |=> $stable(act_ram_sel_ff))
    else $error("ram select changed without the area code");

  sfr_trap_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // [R3]
    sfr_fetch_s ##0 !action_ff |=> FETCH_TRAP_INTERRUPT && status_ff[`IFAT_ST_NMI])
    else $error("register area fetch did not trap");

  ram_free_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // [R1]
    FETCH_VALID && ram_hit && !sfr_hit && !act_ram_sel_ff && !FETCH_TRAP_INTERRUPT
    |=> !FETCH_TRAP_INTERRUPT)
    else $error("ram fetch trapped while ram select is clear");

  data_ignore_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // [R14]
    !(FETCH_VALID && FETCH_OPCODE) && TRAP_RESET_N && !rst_busy |=> TRAP_RESET_N)
    else $error("data access caused a trap reset");

  nmi_hold_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // [R6]
    FETCH_TRAP_INTERRUPT && !NMI_ACK |=> FETCH_TRAP_INTERRUPT)
    else $error("trap interrupt dropped before acknowledge");

  action_rst_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // [R4]
    sfr_fetch_s ##0 action_ff |=> !TRAP_RESET_N && status_ff[`IFAT_ST_RST]
    ##1 !TRAP_RESET_N)
    else $error("trap with action set did not reset");

  osc_restart_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // [R10]
    HF_OSC_RESTART |-> !TRAP_RESET_N && $past(LOW_SPEED_MODE_ONE))
    else $error("oscillator restart without low speed trap reset");

  read_zero_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // [R13]
    ar_hs && (ra == `IFAT_OFS_CTRL1) |=> S_AXI_RVALID && S_AXI_RDATA == 32'h0000_0000)
    else $error("control register read returned data");

endmodule

// ### ifat_cpu_model.sv
// cpu fetch stage and nmi acceptance model facing the address trap block
// assumes the bench calls fetch() from clocked code and sets ack_wait (0 = never accept)
`timescale 1ns/10ps

module ifat_cpu_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic trap_irq,
  input wire logic [7:0] ack_wait,
  output logic fetch_valid,
  output logic fetch_opcode,
  output logic [15:0] fetch_addr,
  output logic nmi_ack
);
  logic [7:0] cnt_ff;
  logic ack_ff;

  assign nmi_ack = ack_ff;

  initial
  begin
    fetch_valid = 1'h0;
    fetch_opcode = 1'h0;
    fetch_addr = 16'h0000;
  end

  // one access per call; address and kind are inverted afterwards so a stale value never matches
  task automatic fetch(input logic [15:0] a, input logic op);
    @(posedge clk);
    fetch_valid <= 1'h1;
    fetch_opcode <= op;
    fetch_addr <= a;
    @(posedge clk);
    fetch_valid <= 1'h0;
    fetch_opcode <= ~op;
    fetch_addr <= ~a;
  endtask

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_ff <= 8'h00;
      ack_ff <= 1'h0;
    end
    else
    begin
      ack_ff <= 1'h0;
      cnt_ff <= 8'h00;
      if (trap_irq && !ack_ff && ack_wait != 8'h00)
      begin
        cnt_ff <= cnt_ff + 8'h01;
        ack_ff <= (cnt_ff + 8'h01 == ack_wait);
      end
    end
  end
endmodule

// ### ifat_tb.sv
// self-checking bench for the address trap block and its register slave
// assumes ifat_top, ifat_params.svh and the cpu model are compiled alongside
`timescale 1ns/10ps
`include "ifat_params.svh"

module testbench;
  localparam int FC = 16000;
  localparam int RST_CYC = 24000000 / FC / 20;
  localparam logic [1:0] OK = `IFAT_RESP_OKAY;
  localparam logic [1:0] ERR = `IFAT_RESP_SLVERR;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic lsm = 1'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [7:0] ack_wait = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, fv, fo, nack, tint, trst_n, hf, irq;
  logic [1:0] bresp, rresp, exp_b;
  logic [31:0] rdata, rnd;
  logic [33:0] exp_r;
  logic [15:0] fa;
  logic [3:0] wd, wd_exp;
  logic [7:0] codes [3] = '{8'h4e, 8'hb1, 8'h00};
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int lows, hfs, i;
  integer seed = 32'h1bce;

  always #10 clk = ~clk;

  ifat_top #(.FC_KHZ(FC)) dut (.CLK_SYS(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .FETCH_VALID(fv), .FETCH_OPCODE(fo), .FETCH_ADDR(fa),
    .NMI_ACK(nack), .LOW_SPEED_MODE_ONE(lsm), .FETCH_TRAP_INTERRUPT(tint),
    .TRAP_RESET_N(trst_n), .HF_OSC_RESTART(hf), .GUARD_WD_FIELDS(wd), .IRQ(irq));

  ifat_cpu_model cpu (.clk(clk), .nrst(nrst), .trap_irq(tint), .ack_wait(ack_wait),
    .fetch_valid(fv), .fetch_opcode(fo), .fetch_addr(fa), .nmi_ack(nack));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // a hung handshake ends here rather than running forever
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      close_out();
    end
  end

  // responses are judged at the handshake edge against the oldest note
  always @(posedge clk)
  begin
    if (rvalid && rready)
    begin
      exp_r = rq.pop_front();
      check("rdata", rdata, exp_r[31:0]);
      check("rresp", 32'(rresp), 32'(exp_r[33:32]));
    end
    if (bvalid && bready)
    begin
      exp_b = bq.pop_front();
      check("bresp", 32'(bresp), 32'(exp_b));
    end
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (!bvalid);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'h0;
    end
    while (!rvalid);
    rready <= 1'h0;
  endtask

  task automatic settle();
    @(negedge clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    rd(`IFAT_OFS_CTRL1, 32'h0000_0000, OK);
    rd(`IFAT_OFS_CODE, 32'h0000_0000, OK);
    rd(`IFAT_OFS_STAT, 32'h0000_0000, OK);
    rd(`IFAT_OFS_MASK, 32'h0000_0000, OK);
    rd(`IFAT_OFS_CFG, 32'h0000_0007, OK);
    rd(8'h20, 32'h0000_0000, ERR);
    check("wd_fields", 32'(wd), 32'h0000_0009);
    // reset response, with the slow mode on for the data access and pass 0
    lsm <= 1'h1;
    cpu.fetch(16'h0010, 1'h0);
    settle();
    check("data_access", {30'h0, tint, trst_n}, 32'h0000_0001);
    // pass 0: register area trap in slow mode; pass 1: ram trap with slow mode off
    for (i = 0; i < 2; i++)
    begin
      cpu.fetch((i == 0) ? 16'h0030 : 16'h0100, 1'h1);
      lows = 0;
      hfs = 0;
      repeat (100)
      begin
        @(negedge clk);
        lows += int'(trst_n === 1'h0);
        hfs += int'(hf === 1'h1);
      end
      check("reset_len", lows, RST_CYC);
      check("osc_restart", hfs, 1 - i);
      rd(`IFAT_OFS_STAT, 32'h0000_0002, OK);
      rd(`IFAT_OFS_STAT, 32'h0000_0000, OK);
      lsm <= 1'h0;
    end
    // interrupt response; ram select written but not yet committed
    rnd = $random(seed);
    wd_exp = rnd[3:0];
    wr(`IFAT_OFS_CTRL1, {28'h000_0000, wd_exp}, 4'h1, OK);
    check("wd_fields", 32'(wd), 32'(wd_exp));
    rd(`IFAT_OFS_CFG, 32'h0000_0001, OK);
    wr(`IFAT_OFS_MASK, 32'h0000_0001, 4'hf, OK);
    cpu.fetch(16'h0040, 1'h1);
    settle();
    check("ram_trap_irq", 32'(tint), 32'h0000_0001);
    settle();
    check("irq_masked_in", 32'(irq), 32'h0000_0001);
    cpu.fetch(16'h003f, 1'h1);
    repeat (4) settle();
    check("trap_held", 32'(tint), 32'h0000_0001);
    @(posedge clk);
    ack_wait <= 8'h03;
    for (i = 0; i < 20 && tint === 1'h1; i++)
      @(negedge clk);
    check("trap_acked", 32'(tint), 32'h0000_0000);
    rd(`IFAT_OFS_STAT, 32'h0000_0001, OK);
    settle();
    check("irq_cleared", 32'(irq), 32'h0000_0000);
    // codes other than the area code leave the selection alone
    foreach (codes[k])
    begin
      wr(`IFAT_OFS_CODE, {24'h00_0000, codes[k]}, 4'h1, OK);
      rd(`IFAT_OFS_CFG, 32'h0000_0001, OK);
    end
    wr(`IFAT_OFS_CODE, 32'h0000_00d2, 4'h0, OK);
    rd(`IFAT_OFS_CFG, 32'h0000_0001, OK);
    wr(8'h20, 32'h0000_00d2, 4'h1, ERR);
    wr(`IFAT_OFS_CODE, 32'h0000_00d2, 4'h1, OK);
    rd(`IFAT_OFS_CFG, 32'h0000_0000, OK);
    cpu.fetch(16'h0240, 1'h1);
    repeat (8)
    begin
      rnd = $random(seed);
      cpu.fetch({7'h00, rnd[8:0]} + 16'h0040, 1'h1);
      cpu.fetch({rnd[15:10] | 6'h01, rnd[9:0]}, 1'h1);
    end
    settle();
    check("ram_free", 32'(tint), 32'h0000_0000);
    wr(`IFAT_OFS_MASK, 32'h0000_0000, 4'hf, OK);
    cpu.fetch(16'h0000, 1'h1);
    settle();
    check("sfr_trap", {30'h0, tint, trst_n}, 32'h0000_0003);
    settle();
    check("irq_masked", 32'(irq), 32'h0000_0000);
    rd(`IFAT_OFS_STAT, 32'h0000_0001, OK);
    close_out();
  end
endmodule
